// [design/asf_adc_end.sv]
// converter end of the serial frame link
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/100ps
`default_nettype none
`include "asf_params.svh"
module asf_adc_end #(
    parameter int unsigned CONV_CYC = (`ASF_CONV_NS + `ASF_CLK_NS - 1) / `ASF_CLK_NS
) (
    // internal conversion oscillator and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // serial link
    asf_link_if.dev link,
    // sampled analog levels of the five inputs
    input wire logic [`ASF_RES_W-1:0] input_channel_0,
    input wire logic [`ASF_RES_W-1:0] input_channel_1,
    input wire logic [`ASF_RES_W-1:0] input_channel_2,
    input wire logic [`ASF_RES_W-1:0] input_channel_3,
    input wire logic [`ASF_RES_W-1:0] input_channel_4,
    // user view of the last conversion
    output asf_pkg::asf_code_t conv_code_o,
    output asf_pkg::asf_res_t result_o
);
    import asf_pkg::*;

    // ----------------------------------------
    // constants
    // ----------------------------------------
    localparam logic [15:0] CONV_M1 = 16'(CONV_CYC - 1);

    asf_conv_t c;
    asf_conv_t c_nxt;
    asf_rise_t r;
    asf_rise_t r_nxt;
    asf_fall_t f;
    asf_fall_t f_nxt;
    asf_code_t chan_r;
    asf_code_t chan_nxt;
    logic start_tog_r;
    logic start_tog_nxt;
    logic link_rst_n;
    logic [4:0] k;
    logic [`ASF_WORD_W-1:0] word;
    asf_res_t conv_val;

    // ----------------------------------------
    // link side: serial clock domain
    // ----------------------------------------

    // raised chip select restarts the port; frames start at its fall
    assign link_rst_n = arst_n_i & ~link.cs_n;

    // outgoing frame: result, then zero pad
    assign word = {c.res, {`ASF_PAD_W{1'b0}}};

    // rising edges: shift in the channel code
    always_comb begin
        r_nxt = r;
        chan_nxt = chan_r;
        if (r.rcnt == `ASF_LAST_EDGE) begin
            r_nxt.rcnt = '0;
        end else begin
            r_nxt.rcnt = r.rcnt + 5'd1;
        end
        if (r.rcnt <= `ASF_CODE_LAST) begin
            r_nxt.code_sr = {r.code_sr[`ASF_CODE_W-2:0], link.mosi};
        end
        if (r.rcnt == `ASF_CODE_LAST) begin
            // only the leading nibble selects; later bits fall through
            chan_nxt = {r.code_sr[`ASF_CODE_W-2:0], link.mosi};
        end
    end

    always_ff @(posedge link.sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            r <= '0;
        end else begin
            r <= r_nxt;
        end
    end

    // the selected channel must survive the chip select going high
    always_ff @(posedge link.sclk or negedge arst_n_i) begin
        if (!arst_n_i) begin
            chan_r <= '0;
        end else begin
            chan_r <= chan_nxt;
        end
    end

    // falling edges: present next result bit, start conversion
    always_comb begin
        f_nxt = f;
        start_tog_nxt = start_tog_r;
        k = f.fcnt + 5'd1;
        if (f.fcnt == `ASF_LAST_EDGE) begin
            f_nxt.fcnt = '0;
        end else begin
            f_nxt.fcnt = k;
        end
        if (k < `ASF_RES_FALLS) begin
            f_nxt.dout = word[`ASF_WORD_MSB - k[3:0]];
        end else begin
            f_nxt.dout = 1'b0;
        end
        if (k == `ASF_RES_FALLS) begin
            start_tog_nxt = ~start_tog_r;
        end
    end

    always_ff @(negedge link.sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            f <= '0;
        end else begin
            f <= f_nxt;
        end
    end

    // the start toggle keeps its level across frames
    always_ff @(negedge link.sclk or negedge arst_n_i) begin
        if (!arst_n_i) begin
            start_tog_r <= 1'b0;
        end else begin
            start_tog_r <= start_tog_nxt;
        end
    end

    // first result bit must show before any clock edge of the frame
    assign link.miso = (f.fcnt == '0) ? c.res[`ASF_RES_MSB] : f.dout;
    assign link.miso_oe = ~link.cs_n;
    assign link.conversion_done_flag = c.eoc;

    // ----------------------------------------
    // conversion side: oscillator domain
    // ----------------------------------------

    // code decode; unused codes convert as zero
    always_comb begin
        case (c.code)
            4'h0: conv_val = input_channel_0;
            4'h1: conv_val = input_channel_1;
            4'h2: conv_val = input_channel_2;
            4'h3: conv_val = input_channel_3;
            `ASF_CODE_CH_MAX: conv_val = input_channel_4;
            `ASF_CODE_HALF: conv_val = `ASF_RES_HALF;
            `ASF_CODE_ZERO: conv_val = `ASF_RES_ZERO;
            `ASF_CODE_FULL: conv_val = `ASF_RES_FULL;
            default: conv_val = `ASF_RES_ZERO;
        endcase
    end

    // start pulse from toggle; chan is quasi-static by then
    always_comb begin
        c_nxt = c;
        c_nxt.tog_s1 = start_tog_r;
        c_nxt.tog_s2 = c.tog_s1;
        c_nxt.tog_s3 = c.tog_s2;
        if (c.tog_s2 ^ c.tog_s3) begin
            c_nxt.busy = 1'b1;
            c_nxt.eoc = 1'b0;
            c_nxt.cnt = '0;
            c_nxt.code = chan_r;
        end else if (c.busy) begin
            if (c.cnt == CONV_M1) begin
                c_nxt.busy = 1'b0;
                c_nxt.eoc = 1'b1;
                c_nxt.res = conv_val;
            end else begin
                c_nxt.cnt = c.cnt + 16'd1;
            end
        end
    end

    // flag starts high: the empty first result may be read at once
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            c <= '0;
            c.eoc <= 1'b1;
        end else begin
            c <= c_nxt;
        end
    end

    // ----------------------------------------
    // user outputs
    // ----------------------------------------
    assign conv_code_o = c.code;
    assign result_o = c.res;
endmodule // asf_adc_end
`default_nettype wire

// [design/asf_fifo.sv]
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module asf_fifo #(
    parameter int W = 10,
    parameter int D = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } asf_fifo_st_t;
    asf_fifo_st_t r;
    asf_fifo_st_t r_nxt;
    logic [W-1:0] mem [D];
    logic full;
    logic empty;
    logic do_wr;
    logic do_rd;

    // extra pointer bit tells full from empty
    assign empty = (r.wp == r.rp);
    assign full = (r.wp[AW] != r.rp[AW]) && (r.wp[AW-1:0] == r.rp[AW-1:0]);
    assign in_ready_o = ~full;
    assign out_valid_o = ~empty;
    assign out_data_o = mem[r.rp[AW-1:0]];
    assign do_wr = in_valid_i & ~full;
    assign do_rd = out_ready_i & ~empty;

    // pointer update
    always_comb begin
        r_nxt = r;
        if (do_wr) begin
            r_nxt.wp = r.wp + 1'b1;
        end
        if (do_rd) begin
            r_nxt.rp = r.rp + 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            r <= '0;
        end else begin
            r <= r_nxt;
        end
    end

    // storage has no reset; empty flag hides stale words
    always_ff @(posedge clk_i) begin
        if (do_wr) begin
            mem[r.wp[AW-1:0]] <= in_data_i;
        end
    end
endmodule // asf_fifo
`default_nettype wire

// [design/asf_host_end.sv]
// host end: serial port master with result fifo
`timescale 1ns/100ps
`default_nettype none
`include "asf_params.svh"
module asf_host_end (
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // serial link
    asf_link_if.host link,
    // conversion requests
    input wire logic req_valid_i,
    input wire asf_pkg::asf_code_t req_code_i,
    input wire logic split_i,
    output logic req_ready_o,
    // results, zero pad already removed
    output logic res_valid_o,
    input wire logic res_ready_i,
    output asf_pkg::asf_res_t res_data_o
);
    import asf_pkg::*;

    // ----------------------------------------
    // timing counts
    // ----------------------------------------
    localparam logic [3:0] HALF_M1 = 4'((`ASF_SCLK_HALF_NS + `ASF_CLK_NS - 1) / `ASF_CLK_NS - 1);
    localparam logic [3:0] GAP_M1 = 4'((`ASF_GAP_NS + `ASF_CLK_NS - 1) / `ASF_CLK_NS - 1);

    asf_host_t r;
    asf_host_t n;
    logic fifo_in_ready;

    // ----------------------------------------
    // frame sequencer
    // ----------------------------------------
    always_comb begin
        n = r;
        n.eoc_s1 = link.conversion_done_flag;
        n.eoc_s2 = r.eoc_s1;
        n.miso_s1 = link.miso_line;
        n.miso_s2 = r.miso_s1;
        n.push = 1'b0;
        n.req_ready = 1'b0;
        // old result is gone once the flag has been seen low
        if (!r.eoc_s2) begin
            n.wait_low = 1'b0;
        end
        case (r.st)
            HS_IDLE: begin
                // fifo space is reserved before the frame starts; a push in flight owns a slot
                n.req_ready = r.eoc_s2 & ~r.wait_low & fifo_in_ready & ~r.push;
                if (r.req_ready && req_valid_i) begin
                    n.req_ready = 1'b0;
                    n.cs_n = 1'b0;
                    // don't-care tail sent as ones, so the far end must skip it
                    n.tx = {req_code_i, {(`ASF_WORD_W-`ASF_CODE_W){1'b1}}};
                    n.mosi = req_code_i[`ASF_CODE_W-1];
                    n.bcnt = '0;
                    n.ph = '0;
                    n.wait_low = 1'b1;
                    n.st = HS_LOW;
                end
            end
            HS_LOW: begin
                if (r.ph == HALF_M1) begin
                    n.sclk = 1'b1;
                    n.ph = '0;
                    n.st = HS_HIGH;
                end else begin
                    n.ph = r.ph + 4'd1;
                end
            end
            HS_HIGH: begin
                if (r.ph == HALF_M1) begin
                    // miso stable since the previous fall, sync delay absorbed
                    n.sclk = 1'b0;
                    n.ph = '0;
                    n.rx = {r.rx[`ASF_WORD_W-2:0], r.miso_s2};
                    n.tx = {r.tx[`ASF_WORD_W-2:0], 1'b0};
                    n.mosi = r.tx[`ASF_WORD_W-2];
                    n.bcnt = r.bcnt + 5'd1;
                    if (r.bcnt == `ASF_LAST_EDGE) begin
                        n.st = HS_DONE;
                    end else if (split_i && r.bcnt == `ASF_BURST_LAST) begin
                        n.st = HS_GAP;
                    end else begin
                        n.st = HS_LOW;
                    end
                end else begin
                    n.ph = r.ph + 4'd1;
                end
            end
            HS_GAP: begin
                if (r.ph == GAP_M1) begin
                    n.ph = '0;
                    n.st = HS_LOW;
                end else begin
                    n.ph = r.ph + 4'd1;
                end
            end
            HS_DONE: begin
                n.cs_n = 1'b1;
                n.push = 1'b1;
                n.st = HS_IDLE;
            end
            default: begin
                n.st = HS_IDLE;
                n.cs_n = 1'b1;
                n.sclk = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            r <= '0;
            r.st <= HS_IDLE;
            r.cs_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // ----------------------------------------
    // result buffer and link outputs
    // ----------------------------------------
    asf_fifo #(
        .W(`ASF_RES_W),
        .D(`ASF_FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .in_valid_i(r.push),
        .in_ready_o(fifo_in_ready),
        .in_data_i(r.rx[`ASF_WORD_W-1:`ASF_PAD_W]),
        .out_valid_o(res_valid_o),
        .out_ready_i(res_ready_i),
        .out_data_o(res_data_o)
    );

    assign link.sclk = r.sclk;
    assign link.cs_n = r.cs_n;
    assign link.mosi = r.mosi;
    assign req_ready_o = r.req_ready;
endmodule // asf_host_end
`default_nettype wire

// [design/asf_link_if.sv]
// serial link between the host port and the converter
`timescale 1ns/100ps
`default_nettype none
interface asf_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic conversion_done_flag;
    // level on the shared data-out wire, pulled low when undriven
    logic miso_line;
    assign miso_line = miso_oe & miso;
    modport dev (input sclk, input cs_n, input mosi, output miso, output miso_oe,
                 output conversion_done_flag);
    modport host (output sclk, output cs_n, output mosi, input miso_line,
                  input conversion_done_flag);
endinterface : asf_link_if
`default_nettype wire

// [design/asf_params.svh]
// constants for the adc serial frame format block
`ifndef ASF_PARAMS_SVH
`define ASF_PARAMS_SVH
// ----------------------------------------
// frame layout
// ----------------------------------------
`define ASF_CODE_W 4
`define ASF_RES_W 10
`define ASF_WORD_W 16
`define ASF_PAD_W 6
`define ASF_CODE_LAST 5'd3
`define ASF_RES_FALLS 5'd10
`define ASF_LAST_EDGE 5'd15
`define ASF_BURST_LAST 5'd7
`define ASF_RES_MSB 4'd9
`define ASF_WORD_MSB 4'd15
// ----------------------------------------
// channel and test codes, test results
// ----------------------------------------
`define ASF_CODE_CH_MAX 4'h4
`define ASF_CODE_HALF 4'hb
`define ASF_CODE_ZERO 4'hc
`define ASF_CODE_FULL 4'hd
`define ASF_RES_HALF 10'h200
`define ASF_RES_ZERO 10'h000
`define ASF_RES_FULL 10'h3ff
// ----------------------------------------
// timing and result fifo depth
// ----------------------------------------
`define ASF_CLK_NS 40
`define ASF_CONV_NS 2000
`define ASF_SCLK_HALF_NS 160
`define ASF_GAP_NS 400
`define ASF_FIFO_DEPTH 8
`endif

// [design/asf_pkg.sv]
// types shared by both ends of the adc serial frame link
`include "asf_params.svh"
package asf_pkg;
    typedef logic [`ASF_CODE_W-1:0] asf_code_t;
    typedef logic [`ASF_RES_W-1:0] asf_res_t;
    typedef enum logic [2:0] {HS_IDLE, HS_LOW, HS_HIGH, HS_GAP, HS_DONE} asf_hst_t;
    // conversion side of the device, on the oscillator clock
    typedef struct packed {
        logic tog_s1;
        logic tog_s2;
        logic tog_s3;
        logic busy;
        logic [15:0] cnt;
        logic eoc;
        asf_code_t code;
        asf_res_t res;
    } asf_conv_t;
    // link side of the device, rising serial clock edges
    typedef struct packed {
        logic [4:0] rcnt;
        asf_code_t code_sr;
    } asf_rise_t;
    // link side of the device, falling serial clock edges
    typedef struct packed {
        logic [4:0] fcnt;
        logic dout;
    } asf_fall_t;
    // host end
    typedef struct packed {
        asf_hst_t st;
        logic [3:0] ph;
        logic [4:0] bcnt;
        logic [`ASF_WORD_W-1:0] tx;
        logic [`ASF_WORD_W-1:0] rx;
        logic sclk;
        logic cs_n;
        logic mosi;
        logic push;
        logic wait_low;
        logic req_ready;
        logic eoc_s1;
        logic eoc_s2;
        logic miso_s1;
        logic miso_s2;
    } asf_host_t;
endpackage : asf_pkg

// [sim/asf_link_properties.sv]
// concurrent checks on the link wires between host end and converter end
`timescale 1ns/100ps
`default_nettype none
module asf_link_properties (
    // host clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // link wires
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso_oe,
    input wire logic miso_line,
    input wire logic conversion_done_flag
);
    logic sclk_r;
    logic [4:0] nfall_r;
    logic rise;
    logic fall;
    // sclk is made from clk_i, so its edges are seen one cycle late
    assign rise = sclk & ~sclk_r;
    assign fall = sclk_r & ~sclk;
    // falls counted per frame, cleared while deselected
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sclk_r <= 1'b0;
            nfall_r <= 5'h00;
        end else begin
            sclk_r <= sclk;
            nfall_r <= cs_n ? 5'h00 : nfall_r + {4'h0, fall};
        end
    end
    // ----
    // properties
    // ----
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_tenth;
        fall && nfall_r == 5'd9;
    endsequence
    sequence s_flag_low;
        (!conversion_done_flag) [*8];
    endsequence
    a_oe_follows_select: assert property (miso_oe == !cs_n)
        else $error("data out enable differs from select");
    a_idle_clock_low: assert property (cs_n |-> !sclk)
        else $error("serial clock high while deselected");
    a_select_full_frame: assert property ($rose(cs_n) |-> (nfall_r + {4'h0, fall}) == 5'd16)
        else $error("frame closed without sixteen clocks");
    a_clock_half_period: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
        else $error("serial clock high phase not four cycles");
    a_flag_low_tenth: assert property (s_tenth |-> ##[1:12] !conversion_done_flag)
        else $error("done flag not low after tenth fall");
    a_flag_high_early: assert property (!cs_n && nfall_r < 5'd10 |-> conversion_done_flag)
        else $error("done flag low before tenth fall");
    a_conv_completes: assert property ($fell(conversion_done_flag) |-> s_flag_low ##[1:40] conversion_done_flag)
        else $error("conversion time out of range");
    a_pad_bits_zero: assert property (rise && nfall_r >= 5'd10 |-> !miso_line)
        else $error("padding bit not zero");
    a_out_steady_high: assert property (sclk && sclk_r |-> $stable(miso_line))
        else $error("data out moved while clock high");
    a_in_steady_high: assert property (sclk && sclk_r |-> $stable(mosi))
        else $error("data in moved while clock high");
    a_no_start_busy: assert property ($fell(cs_n) |-> conversion_done_flag)
        else $error("frame started during conversion");
endmodule // asf_link_properties
`default_nettype wire

// [sim/tb_adc_serial_frame_format.sv]
// self-checking bench: host end and converter end joined by the link
`timescale 1ns/100ps
`default_nettype none
module tb_adc_serial_frame_format;
    import asf_pkg::*;
    logic clk_i;
    logic osc_clk;
    logic arst_n_i;
    logic req_valid_i;
    asf_code_t req_code_i;
    logic split_i;
    logic req_ready_o;
    logic res_valid_o;
    logic res_ready_i;
    asf_res_t res_data_o;
    asf_code_t conv_code_o;
    asf_res_t result_o;
    logic [9:0] ain [5] = '{10'h3a5, 10'h15a, 10'h2c3, 10'h001, 10'h3fe};
    asf_res_t prev_r;
    logic [15:0] cap_miso;
    logic [15:0] cap_mosi;
    int err_total;
    int n_tests;
    asf_link_if link ();
    asf_adc_end #(.CONV_CYC(20)) u_asf_adc_end (.clk_i(osc_clk), .arst_n_i(arst_n_i), .link(link),
        .input_channel_0(ain[0]), .input_channel_1(ain[1]), .input_channel_2(ain[2]),
        .input_channel_3(ain[3]), .input_channel_4(ain[4]), .conv_code_o(conv_code_o), .result_o(result_o));
    asf_host_end u_asf_host_end (.clk_i(clk_i), .arst_n_i(arst_n_i), .link(link), .req_valid_i(req_valid_i),
        .req_code_i(req_code_i), .split_i(split_i), .req_ready_o(req_ready_o), .res_valid_o(res_valid_o),
        .res_ready_i(res_ready_i), .res_data_o(res_data_o));
    asf_link_properties u_asf_link_properties (.clk_i(clk_i), .arst_n_i(arst_n_i), .sclk(link.sclk),
        .cs_n(link.cs_n), .mosi(link.mosi), .miso_oe(link.miso_oe), .miso_line(link.miso_line),
        .conversion_done_flag(link.conversion_done_flag));
    // host clock, and an unrelated converter oscillator
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    initial begin
        osc_clk = 1'b0;
        #7;
        forever #16 osc_clk = ~osc_clk;
    end
    // wire view of each frame, taken where the converter samples
    always @(posedge link.sclk) begin
        cap_miso <= {cap_miso[14:0], link.miso_line};
        cap_mosi <= {cap_mosi[14:0], link.mosi};
    end
    // ----
    // shared tasks
    // ----
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic asf_res_t expect_of(input asf_code_t c);
        case (c)
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4: expect_of = ain[c[2:0]];
            4'hb: expect_of = 10'h200;
            4'hc: expect_of = 10'h000;
            4'hd: expect_of = 10'h3ff;
            default: expect_of = 10'h000;
        endcase
    endfunction
    // bounded wait for the take, then one idle edge before the next
    task automatic request(input asf_code_t code, input logic split);
        int n;
        n = 0;
        req_code_i <= code;
        split_i <= split;
        req_valid_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (req_ready_o !== 1'b1 && n < 2000);
        check({15'h0000, req_ready_o}, 16'h0001);
        req_valid_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic receive(input asf_res_t exp);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (!(res_valid_o === 1'b1 && res_ready_i === 1'b1) && n < 2000);
        check({5'h00, res_valid_o, res_data_o}, {5'h00, 1'b1, exp});
    endtask
    // one frame: prior result back, new code out
    task automatic xfer(input asf_code_t code, input logic split);
        asf_res_t e;
        e = prev_r;
        request(code, split);
        receive(e);
        check(cap_miso, {e, 6'h00});
        check({12'h000, cap_mosi[15:12]}, {12'h000, code});
        check({12'h000, conv_code_o}, {12'h000, code});
        check({6'h00, result_o}, {6'h00, expect_of(code)});
        prev_r = expect_of(code);
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_scan();
        for (int c = 0; c < 5; c++) xfer(c[3:0], 1'b0);
    endtask
    task automatic t_codes();
        // only codes that select an input or a test are ever sent
        asf_code_t list [12] = '{4'hb, 4'hc, 4'hd, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hd, 4'hb, 4'hc, 4'h0};
        foreach (list[i]) xfer(list[i], i[0]);
    endtask
    // results pile up with the far side stalled, then drain to empty
    task automatic t_fifo_full();
        res_ready_i <= 1'b0;
        for (int i = 0; i < 8; i++) request(4'h1, i[0]);
        repeat (400) @(posedge clk_i);
        check({15'h0000, req_ready_o}, 16'h0000);
        res_ready_i <= 1'b1;
        receive(prev_r);
        repeat (7) receive(ain[1]);
        @(posedge clk_i);
        check({15'h0000, res_valid_o}, 16'h0000);
        prev_r = ain[1];
    endtask
    // reset in mid-frame: the port comes back empty
    task automatic t_reset_mid();
        request(4'h2, 1'b0);
        repeat (40) @(posedge clk_i);
        arst_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        check({15'h0000, link.cs_n}, 16'h0001);
        arst_n_i <= 1'b1;
        prev_r = 10'h000;
        xfer(4'h3, 1'b0);
        xfer(4'h4, 1'b1);
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // hang guard, well beyond the few thousand cycles expected
    initial begin
        #1600000;
        err_total++;
        complete_run();
    end
    initial begin
        err_total = 0;
        n_tests = 0;
        arst_n_i = 1'b0;
        req_valid_i = 1'b0;
        req_code_i = 4'h0;
        split_i = 1'b0;
        res_ready_i = 1'b1;
        prev_r = 10'h000;
        repeat (12) @(posedge clk_i);
        arst_n_i <= 1'b1;
        t_scan();
        t_codes();
        t_fifo_full();
        t_reset_mid();
        complete_run();
    end
endmodule // tb_adc_serial_frame_format
`default_nettype wire
